//--- hdl/port_reset_pad_control.sv
// top: reset pad sequencing, port configuration registers, AXI4-Lite slave
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module port_reset_pad_control (
  input  wire logic               i_clk,
  input  wire logic               i_arst_n,
  input  wire logic               i_wdg_rst,
  input  wire logic               i_sw_rst,
  input  wire logic [31:0]        i_awaddr,
  input  wire logic               i_awvalid,
  output logic                    o_awready,
  input  wire logic [31:0]        i_wdata,
  input  wire logic [3:0]         i_wstrb,
  input  wire logic               i_wvalid,
  output logic                    o_wready,
  output logic [1:0]              o_bresp,
  output logic                    o_bvalid,
  input  wire logic               i_bready,
  input  wire logic [31:0]        i_araddr,
  input  wire logic               i_arvalid,
  output logic                    o_arready,
  output logic [31:0]             o_rdata,
  output logic [1:0]              o_rresp,
  output logic                    o_rvalid,
  input  wire logic               i_rready,
  output port_pad_pkg::pad_ctrl_s o_pad,
  output logic                    o_high_drive_ports,
  output logic                    o_high_drive_strobes
);
  import port_pad_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset merge: pin reset is async; watchdog and software resets are
  // same-clock pulses registered into one reset flop, int_rst_q, so all share one path
  logic int_rst_q, int_rst_d;
  logic core_rst_n;

  always_comb begin
    int_rst_d = i_wdg_rst || i_sw_rst;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      int_rst_q <= 1'b0;
    end else begin
      int_rst_q <= int_rst_d;
    end
  end

  // glitch-free: int_rst_q is a flop, so the combined reset has no hazard
  assign core_rst_n = i_arst_n && !int_rst_q;

  ////////////////////////////////////////////////////////////////////////////
  // delay sequencer
  logic       live;
  pad_phase_e phase;

  pad_reset_delay u_delay (
    .i_clk   (i_clk),
    .i_rst_n (core_rst_n),
    .o_live  (live),
    .o_phase (phase)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers
  port_cfg_s   cfg_q, cfg_d;
  logic [31:0] ext_mem1_q, ext_mem1_d;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel
  logic        aw_have_q, aw_have_d;
  logic        w_have_q, w_have_d;
  logic [7:0]  awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        awready_q, awready_d;
  logic        wready_q, wready_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  logic        do_write;

  always_comb begin
    aw_have_d  = aw_have_q;
    w_have_d   = w_have_q;
    awaddr_d   = awaddr_q;
    wdata_d    = wdata_q;
    wstrb_d    = wstrb_q;
    bvalid_d   = bvalid_q;
    bresp_d    = bresp_q;
    cfg_d      = cfg_q;
    ext_mem1_d = ext_mem1_q;
    do_write   = 1'b0;
    if (awready_q && i_awvalid) begin
      aw_have_d = 1'b1;
      awaddr_d  = i_awaddr[7:0];
    end
    if (wready_q && i_wvalid) begin
      w_have_d = 1'b1;
      wdata_d  = i_wdata;
      wstrb_d  = i_wstrb;
    end
    if (aw_have_q && w_have_q && !bvalid_q) begin
      do_write  = 1'b1;
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_OKAY;
      case (awaddr_q)
        CFG_A_OFS:    cfg_d.cfg_a = merge(cfg_q.cfg_a, wdata_q, wstrb_q);
        CFG_B_OFS:    cfg_d.cfg_b = merge(cfg_q.cfg_b, wdata_q, wstrb_q);
        CFG_C_OFS:    cfg_d.cfg_c = merge(cfg_q.cfg_c, wdata_q, wstrb_q);
        EXT_MEM1_OFS: ext_mem1_d  = merge(ext_mem1_q, wdata_q, wstrb_q);
        STATUS_OFS:   bresp_d     = RESP_OKAY;
        default:      bresp_d     = RESP_SLVERR;
      endcase
    end else if (bvalid_q && i_bready) begin
      bvalid_d = 1'b0;
    end
    // accept one address and one data per write; hold off until answered
    awready_d = !aw_have_d && !bvalid_d && !do_write;
    wready_d  = !w_have_d && !bvalid_d && !do_write;
  end

  always_ff @(posedge i_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      cfg_q      <= '{cfg_a: CFG_RST, cfg_b: CFG_RST, cfg_c: CFG_RST};
      ext_mem1_q <= EXT_MEM1_RST;
      aw_have_q  <= 1'b0;
      w_have_q   <= 1'b0;
      awaddr_q   <= 8'h00;
      wdata_q    <= 32'h0000_0000;
      wstrb_q    <= 4'h0;
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= RESP_OKAY;
    end else begin
      cfg_q      <= cfg_d;
      ext_mem1_q <= ext_mem1_d;
      aw_have_q  <= aw_have_d;
      w_have_q   <= w_have_d;
      awaddr_q   <= awaddr_d;
      wdata_q    <= wdata_d;
      wstrb_q    <= wstrb_d;
      awready_q  <= awready_d;
      wready_q   <= wready_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel
  logic        arready_q, arready_d;
  logic        rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  rresp_q, rresp_d;

  always_comb begin
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (arready_q && i_arvalid) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      case (i_araddr[7:0])
        CFG_A_OFS:    rdata_d = cfg_q.cfg_a;
        CFG_B_OFS:    rdata_d = cfg_q.cfg_b;
        CFG_C_OFS:    rdata_d = cfg_q.cfg_c;
        EXT_MEM1_OFS: rdata_d = ext_mem1_q;
        STATUS_OFS:   rdata_d = {29'h0000_0000, phase};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && i_rready) begin
      rvalid_d = 1'b0;
    end
    arready_d = !rvalid_d && !(arready_q && i_arvalid);
  end

  always_ff @(posedge i_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad control outputs, registered
  pad_ctrl_s pad_d, pad_q;
  logic      hd_q, hd_d;

  pad_mode_decode u_decode (
    .i_cfg  (cfg_q),
    .i_live (live),
    .o_ctrl (pad_d)
  );

  always_comb begin
    hd_d = ext_mem1_q[HDS_BIT];
  end

  // one cycle of output latency; the hold state still covers the reset
  // itself because the flops reset straight to floating
  always_ff @(posedge i_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      pad_q <= '{hiz: AFFECTED_MASK, weak_pullup: ~AFFECTED_MASK, analog: 32'h0000_0000};
      hd_q  <= 1'b0;
    end else begin
      pad_q <= pad_d;
      hd_q  <= hd_d;
    end
  end

  assign o_pad                = pad_q;
  assign o_high_drive_ports   = hd_q;
  assign o_high_drive_strobes = hd_q;
  assign o_awready = awready_q;
  assign o_wready  = wready_q;
  assign o_bvalid  = bvalid_q;
  assign o_bresp   = bresp_q;
  assign o_arready = arready_q;
  assign o_rvalid  = rvalid_q;
  assign o_rdata   = rdata_q;
  assign o_rresp   = rresp_q;
endmodule : port_reset_pad_control

//--- hdl/port_pad_pkg.sv
// package: constants, modes and carriers for the reset pad sequencer
package port_pad_pkg;
  localparam int unsigned CLK_HZ                = 10_000_000;
  localparam int unsigned POST_RESET_PAD_CYCLES = 20400;
  localparam int unsigned DLY_W                 = 15;
  localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(POST_RESET_PAD_CYCLES - 1);

  // affected bits of ports 1, 4, 8 and 9
  localparam logic [7:0] P1_MASK = 8'hF8;
  localparam logic [7:0] P4_MASK = 8'h02;
  localparam logic [7:0] P8_MASK = 8'hFC;
  localparam logic [7:0] P9_MASK = 8'hFF;
  localparam logic [31:0] AFFECTED_MASK = {P9_MASK, P8_MASK, P4_MASK, P1_MASK};

  // register byte offsets
  localparam logic [7:0] CFG_A_OFS    = 8'h00;
  localparam logic [7:0] CFG_B_OFS    = 8'h04;
  localparam logic [7:0] CFG_C_OFS    = 8'h08;
  localparam logic [7:0] EXT_MEM1_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS   = 8'h10;
  localparam int unsigned HDS_BIT     = 1;
  localparam logic [31:0] CFG_RST     = 32'h0000_0000;
  localparam logic [31:0] EXT_MEM1_RST = 32'h0000_0000;
  localparam logic [2:0]  ANALOG_CODE = 3'h7;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PAD_HOLD  = 3'h1,
    PAD_DELAY = 3'h2,
    PAD_LIVE  = 3'h4
  } pad_phase_e;

  typedef struct packed {
    logic [31:0] cfg_a;
    logic [31:0] cfg_b;
    logic [31:0] cfg_c;
  } port_cfg_s;

  typedef struct packed {
    logic [31:0] hiz;
    logic [31:0] weak_pullup;
    logic [31:0] analog;
  } pad_ctrl_s;
endpackage : port_pad_pkg

//--- hdl/pad_reset_delay.sv
// post-reset pad delay counter and phase machine
`timescale 1ns/1ps
module pad_reset_delay (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  output logic                          o_live,
  output port_pad_pkg::pad_phase_e      o_phase
);
  import port_pad_pkg::*;

  pad_phase_e       phase_q, phase_d;
  logic [DLY_W-1:0] cnt_q, cnt_d;

  always_comb begin
    phase_d = phase_q;
    cnt_d   = cnt_q;
    case (phase_q)
      PAD_HOLD: begin
        phase_d = PAD_DELAY;
        cnt_d   = '0;
      end
      PAD_DELAY: begin
        if (cnt_q == DLY_LAST) begin
          phase_d = PAD_LIVE;
        end else begin
          cnt_d = cnt_q + DLY_W'(1);
        end
      end
      PAD_LIVE: phase_d = PAD_LIVE;
      default: begin
        phase_d = PAD_HOLD;
        cnt_d   = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_q <= PAD_HOLD;
      cnt_q   <= '0;
    end else begin
      phase_q <= phase_d;
      cnt_q   <= cnt_d;
    end
  end

  assign o_live  = (phase_q == PAD_LIVE);
  assign o_phase = phase_q;
endmodule : pad_reset_delay

//--- hdl/pad_mode_decode.sv
// per-bit pad mode decode from the three configuration registers
`timescale 1ns/1ps
module pad_mode_decode (
  input  port_pad_pkg::port_cfg_s i_cfg,
  input  wire logic               i_live,
  output port_pad_pkg::pad_ctrl_s o_ctrl
);
  import port_pad_pkg::*;

  function automatic logic [2:0] code_of(input port_cfg_s c, input int unsigned b);
    code_of = {c.cfg_c[b], c.cfg_b[b], c.cfg_a[b]};
  endfunction : code_of

  always_comb begin
    o_ctrl = '0;
    for (int unsigned b = 0; b < 32; b++) begin
      o_ctrl.analog[b] = (code_of(i_cfg, b) == ANALOG_CODE);
      if (AFFECTED_MASK[b]) begin
        o_ctrl.hiz[b]         = !i_live;
        o_ctrl.weak_pullup[b] = i_live && (code_of(i_cfg, b) == 3'h0);
      end else begin
        o_ctrl.weak_pullup[b] = (code_of(i_cfg, b) == 3'h0);
      end
    end
  end
endmodule : pad_mode_decode

//--- sim/port_reset_pad_control_monitor.sv
// checker: pad sequencing and bus handshake properties
`timescale 1ns/1ps
module port_reset_pad_control_monitor (
  input wire logic                    i_clk,
  input wire logic                    i_arst_n,
  input wire logic                    i_wdg_rst,
  input wire logic                    i_sw_rst,
  input wire logic                    i_bready,
  input wire logic                    o_arready,
  input wire logic                    o_bvalid,
  input wire logic                    o_rvalid,
  input wire port_pad_pkg::pad_ctrl_s o_pad,
  input wire logic                    o_high_drive_ports,
  input wire logic                    o_high_drive_strobes
);
  import port_pad_pkg::*;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  ////////////////////////////////////////////////////////////////
  // cycles since the last reset; saturates so it never wraps into the hold window
  always_comb begin
    cnt_d = cnt_q;
    if (i_wdg_rst || i_sw_rst) begin
      cnt_d = '0;
    end else if (cnt_q != 16'hFFFF) begin
      cnt_d = cnt_q + 16'h1;
    end
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  property p_hold_hiz;
    cnt_q < 16'd20400 |-> o_pad.hiz == AFFECTED_MASK;
  endproperty
  a_hold_hiz: assert property (p_hold_hiz) else $error("pads left float early");
  property p_release;
    cnt_q == 16'd20410 |-> (o_pad.hiz & AFFECTED_MASK) == '0;
  endproperty
  a_release: assert property (p_release) else $error("pads still float");
  property p_pulse_hold;
    (i_wdg_rst || i_sw_rst) |=>
      (o_pad.hiz == AFFECTED_MASK && (o_pad.weak_pullup & AFFECTED_MASK) == '0) [*3];
  endproperty
  a_pulse_hold: assert property (p_pulse_hold) else $error("no float on core reset");
  property p_no_float_pull;
    (o_pad.hiz & o_pad.weak_pullup) == '0;
  endproperty
  a_no_float_pull: assert property (p_no_float_pull) else $error("pull-up while float");
  property p_analog_excl;
    (o_pad.analog & o_pad.weak_pullup) == '0;
  endproperty
  a_analog_excl: assert property (p_analog_excl) else $error("analog with pull-up");
  property p_drive_pair;
    o_high_drive_ports == o_high_drive_strobes;
  endproperty
  a_drive_pair: assert property (p_drive_pair) else $error("drive outputs differ");
  property p_drive_reset;
    (i_wdg_rst || i_sw_rst) |=> !o_high_drive_ports;
  endproperty
  a_drive_reset: assert property (p_drive_reset) else $error("drive kept over reset");
  property p_ar_block;
    o_rvalid |-> !o_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while answering");
  property p_b_once;
    o_bvalid && i_bready |=> !o_bvalid;
  endproperty
  a_b_once: assert property (p_b_once) else $error("write answer repeated");
endmodule : port_reset_pad_control_monitor

bind port_reset_pad_control port_reset_pad_control_monitor u_mon (.i_clk, .i_arst_n,
  .i_wdg_rst, .i_sw_rst, .i_bready, .o_arready, .o_bvalid, .o_rvalid, .o_pad,
  .o_high_drive_ports, .o_high_drive_strobes);

//--- sim/tb_port_reset_pad_control.sv
// testbench: reset pad sequencing and register access
`timescale 1ns/1ps
module tb_port_reset_pad_control;
  import port_pad_pkg::*;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic [1:0]  br;
    logic [31:0] rd;
    logic [1:0]  rr;
  } row_s;
  logic        i_clk = 0, i_arst_n = 0, i_wdg_rst = 0, i_sw_rst = 0, i_bready = 0;
  logic        i_awvalid = 0, i_wvalid = 0, i_arvalid = 0, i_rready = 0;
  logic [31:0] i_awaddr = 0, i_wdata = 0, i_araddr = 0;
  logic [3:0]  i_wstrb = 0;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic        o_high_drive_ports, o_high_drive_strobes;
  logic [1:0]  o_bresp, o_rresp;
  logic [31:0] o_rdata;
  pad_ctrl_s   o_pad;
  int          miscompares = 0, checks_done = 0, cyc = 0;
  row_s        rows [6] = '{
    '{CFG_A_OFS, 32'h0000_00FF, RESP_OKAY, 32'h0000_00FF, RESP_OKAY},
    '{CFG_B_OFS, 32'h0000_00F0, RESP_OKAY, 32'h0000_00F0, RESP_OKAY},
    '{CFG_C_OFS, 32'h0000_0030, RESP_OKAY, 32'h0000_0030, RESP_OKAY},
    '{EXT_MEM1_OFS, 32'h0000_0002, RESP_OKAY, 32'h0000_0002, RESP_OKAY},
    '{STATUS_OFS, 32'h0000_0000, RESP_OKAY, 32'h0000_0004, RESP_OKAY},
    '{8'h14, 32'h0000_0001, RESP_SLVERR, 32'h0000_0000, RESP_SLVERR}};

  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= cyc + 1;

  port_reset_pad_control dut (.i_clk, .i_arst_n, .i_wdg_rst, .i_sw_rst, .i_awaddr, .i_awvalid,
    .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
    .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_pad,
    .o_high_drive_ports, .o_high_drive_strobes);
  ////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  // every handshake and release wait goes through here so a hang ends the run
  task automatic tick(inout int n);
    @(posedge i_clk);
    n++;
    if (n > 21000) begin
      miscompares++;
      conclude();
    end
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    int n = 0;
    i_awaddr <= {24'h0, a};
    i_wdata <= d;
    i_wstrb <= s;
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    do begin
      tick(n);
      if (o_awready) i_awvalid <= 1'h0;
      if (o_wready) i_wvalid <= 1'h0;
    end while (!o_bvalid);
    r = o_bresp;
    i_bready <= 1'h0;
    @(posedge i_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    i_araddr <= {24'h0, a};
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    do begin
      tick(n);
      if (o_arready) i_arvalid <= 1'h0;
    end while (!o_rvalid);
    d = o_rdata;
    r = o_rresp;
    i_rready <= 1'h0;
    @(posedge i_clk);
  endtask : rd

  // k: 0 pin, 1 watchdog, 2 software; the request pulses last one cycle
  task automatic rst(input int k);
    logic [31:0] d;
    logic [1:0]  r;
    int          n = 0;
    int          t0;
    if (k == 0) i_arst_n <= 1'h0;
    else if (k == 1) i_wdg_rst <= 1'h1;
    else i_sw_rst <= 1'h1;
    @(posedge i_clk);
    i_wdg_rst <= 1'h0;
    i_sw_rst <= 1'h0;
    repeat (2) @(posedge i_clk);
    chk(o_pad, {AFFECTED_MASK, ~AFFECTED_MASK, 32'h0});
    chk({o_high_drive_ports, o_high_drive_strobes}, 2'h0);
    i_arst_n <= 1'h1;
    t0 = cyc;
    rd(CFG_C_OFS, d, r);
    chk(d, CFG_RST);
    rd(STATUS_OFS, d, r);
    chk(d, 32'h2);
    while ((o_pad.hiz & AFFECTED_MASK) != 0) tick(n);
    chk((cyc - t0) inside {[20401:20405]}, 1'h1);
    chk(o_pad, {32'h0, 32'hFFFF_FFFF, 32'h0});
  endtask : rst
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    rst(0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, 4'hF, r);
      chk(r, rows[i].br);
      rd(rows[i].a, d, r);
      chk({r, d}, {rows[i].rr, rows[i].rd});
    end
    chk(o_pad.analog, 32'h0000_0030);
    chk(o_pad.weak_pullup, 32'hFFFF_FF00);
    chk({o_high_drive_ports, o_high_drive_strobes}, 2'h3);
    // byte lane 0 only: code of bits 4 and 5 drops from 111 to 110
    wr(CFG_A_OFS, 32'hFFFF_FF00, 4'h1, r);
    chk(o_pad.analog, 32'h0);
    rst(1);
    wr(EXT_MEM1_OFS, 32'h2, 4'hF, r);
    rst(2);
    conclude();
  end
endmodule : tb_port_reset_pad_control
